// ---- logic/hpc_pkg.sv ----
// package for the haptic playback configuration register bank:
// register offsets, reset values, field positions, timing counts and carrier structs.
// assumes a 10 MHz core clock and a byte-wide register port behind the serial interface.
package hpc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_WAVEFORM_GAIN   = 8'h39;
	localparam logic [7:0] OFS_BOOST_VOLTAGE   = 8'h3a;
	localparam logic [7:0] OFS_GUARD_LEVEL     = 8'h3e;
	localparam logic [7:0] OFS_GUARD_PERIOD    = 8'h3f;
	localparam logic [7:0] OFS_PTR_HIGH        = 8'h40;
	localparam logic [7:0] OFS_PTR_LOW         = 8'h41;
	localparam logic [7:0] OFS_DATA_PORT       = 8'h42;
	localparam logic [7:0] OFS_CONTINUOUS_DRIVE_CTRL       = 8'h48;
	localparam logic [7:0] OFS_PRESET_HIGH     = 8'h49;
	localparam logic [7:0] OFS_PRESET_LOW      = 8'h4a;
	localparam logic [7:0] OFS_DELAY_HIGH      = 8'h4b;
	localparam logic [7:0] OFS_DELAY_LOW       = 8'h4c;
	localparam logic [7:0] OFS_DIAG_CTRL       = 8'h5f;
	localparam logic [7:0] OFS_LOAD_RES        = 8'h60;
	localparam logic [7:0] OFS_OFFSET          = 8'h61;
	localparam logic [7:0] OFS_SUPPLY          = 8'h62;
	localparam logic [7:0] OFS_ADJUST_CFG      = 8'h66;
	localparam logic [7:0] OFS_MEAS_HIGH       = 8'h68;
	localparam logic [7:0] OFS_MEAS_LOW        = 8'h69;
	localparam logic [7:0] OFS_TRACK_HIGH      = 8'h6a;
	localparam logic [7:0] OFS_TRACK_LOW       = 8'h6b;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_WAVEFORM_GAIN   = 8'h80;
	localparam logic [7:0] RST_BOOST_VOLTAGE   = 8'h62;
	localparam logic [7:0] RST_GUARD_LEVEL     = 8'hbf;
	localparam logic [7:0] RST_GUARD_PERIOD    = 8'h12;
	localparam logic [7:0] RST_CONTINUOUS_DRIVE_CTRL       = 8'h99;
	localparam logic [7:0] RST_PRESET_HIGH     = 8'h07;
	localparam logic [7:0] RST_PRESET_LOW      = 8'h25;
	localparam logic [7:0] RST_DELAY_LOW       = 8'h5d;
	localparam logic [7:0] RST_OFFSET          = 8'h80;
	localparam logic [7:0] RST_ZERO            = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int BOOST_CODE_LSB      = 1;
	localparam int GUARD_ENABLE_BIT    = 7;
	localparam int CONT_PERIODS_LSB    = 5;
	localparam int CONT_DURATION_BIT   = 4;
	localparam int CONT_CLOSED_BIT     = 3;
	localparam int CONT_DETECT_BIT     = 2;
	localparam int CONT_BRAKE_BIT      = 0;
	localparam int DIAG_SELECT_BIT     = 6;
	localparam int DIAG_PROTECT_BIT    = 5;
	localparam int DIAG_SUPPLY_GO_BIT  = 1;
	localparam int DIAG_START_BIT      = 0;
	localparam int ADJUST_MODE_BIT     = 6;

	// boost rail: base and step in millivolts
	localparam logic [13:0] BOOST_BASE_MV = 14'h1770; // 6000 mV
	localparam logic [13:0] BOOST_STEP_MV = 14'h008e; // 142 mV

	// unit gain of the waveform scaler is 0x80, so products shift by 7
	localparam int GAIN_SHIFT = 7;

	////////////////////////////////////////////////////////////////////////////////
	// timing: period counts are in units of 2.6 us
	localparam int CLK_PERIOD_PS = 100000;
	localparam int UNIT_TIME_PS  = 2600000;
	localparam int UNIT_CYCLES   = (UNIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hpc_reg_req_t;

	typedef struct packed {
		logic        diag_done;
		logic [7:0]  diag_value;
		logic        supply_done;
		logic [7:0]  supply_value;
		logic        f0_done;
		logic [15:0] f0_period;
		logic        track_valid;
		logic [15:0] track_period;
	} hpc_meas_t;

	typedef struct packed {
		logic [7:0]  gain;
		logic [4:0]  boost_rail_code;
		logic [13:0] boost_rail_mv;
		logic        input_guard_enable;
		logic [6:0]  input_guard_level;
		logic [7:0]  input_guard_time;
		logic        duration_source_select;
		logic        closed_loop;
		logic        resonance_detect_enable;
		logic        auto_braking_enable;
		logic [2:0]  bemf_periods;
		logic [15:0] preset_period;
		logic [11:0] drive_delay;
		logic        diagnostic_select;
		logic        protection_disable;
		logic        hw_adjust_mode;
		logic        diagnosis_start;
		logic        supply_start;
	} hpc_cfg_t;

endpackage

// ---- logic/hpc_config_regs.sv ----
// configuration and result register bank of the haptic actuator driver, with the
// waveform gain scaler and the indirect wave-memory data port.
// assumes a byte register port already decoded from the serial bus, an external
// wave memory with combinational read, and measurement engines that pulse done.
//
// Overview of operation
// RULE1: one 8-bit gain scales all waveform samples
// RULE2: 5-bit code sets boost rail, 142mV steps
// RULE3: guard enable bit 7, level 6:0, reset 0x3F
// RULE4: 8-bit guard time register, reset 0x12
// RULE5: pointer is five high plus eight low bits
// RULE6: data port moves one byte to/from memory
// RULE7: pointer advances after every data port access
// RULE8: bits 6:5 pick one, two or four periods
// RULE9: bit 4 selects register-timed or go-timed playback
// RULE10: bit 3 selects closed or open loop
// RULE11: bit 2 enables resonance detection
// RULE12: continuous control resets to 0x99
// RULE13: preset period 16 bits, reset 0x0725
// RULE14: 12-bit delay from 4 high, 8 low bits
// RULE15: bit 6 picks resistance or offset measurement
// RULE16: bit 5 high disables output protection
// RULE17: start bit 0 yields resistance result
// RULE18: start bit 1 yields supply result
// RULE19: offset result read-only, reset 0x80
// RULE20: bit 6 picks software or hardware adjust
// RULE21: detected period stored across two bytes
// RULE22: tracked period upper byte register
// RULE23: tracked period lower byte follows, reset zero
// RULE24: start bits clear when results land
`timescale 1ns/1ps
`default_nettype none

module hpc_config_regs #(
	parameter int PTR_WIDTH = 13
) (
	// clock, reset, enable
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic                   clk_en,
	// register port
	input  wire hpc_pkg::hpc_reg_req_t  reg_req,
	output logic [7:0]                  reg_rdata,
	// wave memory
	output logic [PTR_WIDTH-1:0]        mem_raddr,
	input  wire logic [7:0]             mem_rdata,
	output logic                        mem_wr,
	output logic [PTR_WIDTH-1:0]        mem_waddr,
	output logic [7:0]                  mem_wdata,
	// measurement engines
	input  wire hpc_pkg::hpc_meas_t     meas,
	// waveform samples
	input  wire logic                   sample_valid,
	input  wire logic signed [7:0]      sample_in,
	output logic                        scaled_valid,
	output logic signed [7:0]           scaled_out,
	// configuration and timebase
	output hpc_pkg::hpc_cfg_t           cfg,
	output logic                        unit_tick
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [7:0]           gain;
		logic [7:0]           boost;
		logic [7:0]           guard_level;
		logic [7:0]           guard_time;
		logic [7:0]           ptr_hi;
		logic [7:0]           ptr_lo;
		logic [7:0]           data_port;
		logic [7:0]           continuous_drive_ctrl;
		logic [7:0]           pre_hi;
		logic [7:0]           pre_lo;
		logic [7:0]           dly_hi;
		logic [7:0]           dly_lo;
		logic [7:0]           diag_ctrl;
		logic [7:0]           load_res;
		logic [7:0]           offset;
		logic [7:0]           supply;
		logic [7:0]           adjust;
		logic [7:0]           meas_hi;
		logic [7:0]           meas_lo;
		logic [7:0]           trk_hi;
		logic [7:0]           trk_lo;
		logic [7:0]           rdata;
		logic                 mem_wr;
		logic [PTR_WIDTH-1:0] mem_waddr;
		logic [7:0]           mem_wdata;
		logic [4:0]           tick_cnt;
		logic                 tick;
		logic                 out_valid;
		logic [7:0]           out_sample;
	} hpc_state_t;

	localparam logic [4:0] TICK_LAST = 5'(hpc_pkg::UNIT_CYCLES - 1);

	// reset image of the whole state; fields not listed start at zero
	localparam hpc_state_t RESET_STATE = '{
		gain:        hpc_pkg::RST_WAVEFORM_GAIN,  // [RULE1]
		boost:       hpc_pkg::RST_BOOST_VOLTAGE,
		guard_level: hpc_pkg::RST_GUARD_LEVEL,    // [RULE3]
		guard_time:  hpc_pkg::RST_GUARD_PERIOD,   // [RULE4]
		continuous_drive_ctrl:   hpc_pkg::RST_CONTINUOUS_DRIVE_CTRL,      // [RULE12]
		pre_hi:      hpc_pkg::RST_PRESET_HIGH,    // [RULE13]
		pre_lo:      hpc_pkg::RST_PRESET_LOW,     // [RULE13]
		dly_lo:      hpc_pkg::RST_DELAY_LOW,      // [RULE14]
		offset:      hpc_pkg::RST_OFFSET,         // [RULE19]
		default:     '0
	};

	hpc_state_t                  state;
	hpc_state_t                  next_state;
	logic       [PTR_WIDTH-1:0]  ptr;
	logic       [PTR_WIDTH-1:0]  ptr_inc;
	logic                        wr_hit;
	logic                        rd_hit;
	logic signed [16:0]          product;
	logic signed [16:0]          shifted;

	////////////////////////////////////////////////////////////////////////////////
	// access pointer and register-port strobes
	assign ptr     = {state.ptr_hi[4:0], state.ptr_lo}; // [RULE5]
	assign ptr_inc = ptr + 13'h0001;
	assign wr_hit  = clk_en & reg_req.wr;
	assign rd_hit  = clk_en & reg_req.rd;

	// gain product; signed sample times unsigned gain, unity at 0x80
	assign product = 17'(sample_in) * $signed({9'h000, state.gain}); // [RULE1]
	assign shifted = product >>> hpc_pkg::GAIN_SHIFT;

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_state        = state;
		next_state.mem_wr = 1'b0;
		next_state.tick   = 1'b0;

		// writes from the host; read-only results ignore writes
		if (wr_hit) begin
			case (reg_req.addr)
				hpc_pkg::OFS_WAVEFORM_GAIN: next_state.gain        = reg_req.wdata; // [RULE1]
				hpc_pkg::OFS_BOOST_VOLTAGE: next_state.boost       = reg_req.wdata; // [RULE2]
				hpc_pkg::OFS_GUARD_LEVEL:   next_state.guard_level = reg_req.wdata; // [RULE3]
				hpc_pkg::OFS_GUARD_PERIOD:  next_state.guard_time  = reg_req.wdata; // [RULE4]
				hpc_pkg::OFS_PTR_HIGH:      next_state.ptr_hi      = reg_req.wdata; // [RULE5]
				hpc_pkg::OFS_PTR_LOW:       next_state.ptr_lo      = reg_req.wdata; // [RULE5]
				hpc_pkg::OFS_DATA_PORT: begin
					// write goes out one cycle later at the pre-advance pointer
					next_state.data_port = reg_req.wdata;
					next_state.mem_wr    = 1'b1;               // [RULE6]
					next_state.mem_waddr = ptr;                // [RULE6]
					next_state.mem_wdata = reg_req.wdata;      // [RULE6]
					next_state.ptr_hi    = {state.ptr_hi[7:5], ptr_inc[12:8]}; // [RULE7]
					next_state.ptr_lo    = ptr_inc[7:0];                       // [RULE7]
				end
				hpc_pkg::OFS_CONTINUOUS_DRIVE_CTRL:     next_state.continuous_drive_ctrl   = reg_req.wdata; // [RULE9]
				hpc_pkg::OFS_PRESET_HIGH:   next_state.pre_hi      = reg_req.wdata; // [RULE13]
				hpc_pkg::OFS_PRESET_LOW:    next_state.pre_lo      = reg_req.wdata; // [RULE13]
				hpc_pkg::OFS_DELAY_HIGH:    next_state.dly_hi      = reg_req.wdata; // [RULE14]
				hpc_pkg::OFS_DELAY_LOW:     next_state.dly_lo      = reg_req.wdata; // [RULE14]
				hpc_pkg::OFS_DIAG_CTRL:     next_state.diag_ctrl   = reg_req.wdata; // [RULE15]
				hpc_pkg::OFS_ADJUST_CFG:    next_state.adjust      = reg_req.wdata; // [RULE20]
				hpc_pkg::OFS_MEAS_HIGH:     next_state.meas_hi     = reg_req.wdata;
				hpc_pkg::OFS_MEAS_LOW:      next_state.meas_lo     = reg_req.wdata;
				hpc_pkg::OFS_TRACK_HIGH:    next_state.trk_hi      = reg_req.wdata;
				hpc_pkg::OFS_TRACK_LOW:     next_state.trk_lo      = reg_req.wdata;
				default: ;
			endcase
		end

		// reads; a data-port read fetches the byte and advances the pointer
		if (rd_hit) begin
			case (reg_req.addr)
				hpc_pkg::OFS_WAVEFORM_GAIN: next_state.rdata = state.gain;
				hpc_pkg::OFS_BOOST_VOLTAGE: next_state.rdata = state.boost;
				hpc_pkg::OFS_GUARD_LEVEL:   next_state.rdata = state.guard_level;
				hpc_pkg::OFS_GUARD_PERIOD:  next_state.rdata = state.guard_time;
				hpc_pkg::OFS_PTR_HIGH:      next_state.rdata = state.ptr_hi;
				hpc_pkg::OFS_PTR_LOW:       next_state.rdata = state.ptr_lo;
				hpc_pkg::OFS_DATA_PORT: begin
					next_state.rdata     = mem_rdata;          // [RULE6]
					next_state.data_port = mem_rdata;          // [RULE6]
					next_state.ptr_hi    = {state.ptr_hi[7:5], ptr_inc[12:8]}; // [RULE7]
					next_state.ptr_lo    = ptr_inc[7:0];                       // [RULE7]
				end
				hpc_pkg::OFS_CONTINUOUS_DRIVE_CTRL:     next_state.rdata = state.continuous_drive_ctrl;
				hpc_pkg::OFS_PRESET_HIGH:   next_state.rdata = state.pre_hi;
				hpc_pkg::OFS_PRESET_LOW:    next_state.rdata = state.pre_lo;
				hpc_pkg::OFS_DELAY_HIGH:    next_state.rdata = state.dly_hi;
				hpc_pkg::OFS_DELAY_LOW:     next_state.rdata = state.dly_lo;
				hpc_pkg::OFS_DIAG_CTRL:     next_state.rdata = state.diag_ctrl;
				hpc_pkg::OFS_LOAD_RES:      next_state.rdata = state.load_res;
				hpc_pkg::OFS_OFFSET:        next_state.rdata = state.offset;
				hpc_pkg::OFS_SUPPLY:        next_state.rdata = state.supply;
				hpc_pkg::OFS_ADJUST_CFG:    next_state.rdata = state.adjust;
				hpc_pkg::OFS_MEAS_HIGH:     next_state.rdata = state.meas_hi;
				hpc_pkg::OFS_MEAS_LOW:      next_state.rdata = state.meas_lo;
				hpc_pkg::OFS_TRACK_HIGH:    next_state.rdata = state.trk_hi;
				hpc_pkg::OFS_TRACK_LOW:     next_state.rdata = state.trk_lo;
				default:                    next_state.rdata = hpc_pkg::RST_ZERO;
			endcase
		end

		// diagnostic result lands in resistance or offset by the select bit;
		// a host write of 1 in the same cycle wins over the auto-clear
		if (clk_en && meas.diag_done && state.diag_ctrl[hpc_pkg::DIAG_START_BIT]) begin
			if (state.diag_ctrl[hpc_pkg::DIAG_SELECT_BIT])
				next_state.load_res = meas.diag_value;        // [RULE15] [RULE17]
			else
				next_state.offset = meas.diag_value;          // [RULE15] [RULE19]
			if (!(wr_hit && reg_req.addr == hpc_pkg::OFS_DIAG_CTRL &&
			      reg_req.wdata[hpc_pkg::DIAG_START_BIT]))
				next_state.diag_ctrl[hpc_pkg::DIAG_START_BIT] = 1'b0; // [RULE24]
		end

		// supply measurement result
		if (clk_en && meas.supply_done && state.diag_ctrl[hpc_pkg::DIAG_SUPPLY_GO_BIT]) begin
			next_state.supply = meas.supply_value;            // [RULE18]
			if (!(wr_hit && reg_req.addr == hpc_pkg::OFS_DIAG_CTRL &&
			      reg_req.wdata[hpc_pkg::DIAG_SUPPLY_GO_BIT]))
				next_state.diag_ctrl[hpc_pkg::DIAG_SUPPLY_GO_BIT] = 1'b0; // [RULE24]
		end

		// measured periods; hardware results win over a host write
		if (clk_en && meas.f0_done) begin
			next_state.meas_hi = meas.f0_period[15:8];        // [RULE21]
			next_state.meas_lo = meas.f0_period[7:0];         // [RULE21]
		end
		if (clk_en && meas.track_valid) begin
			next_state.trk_hi = meas.track_period[15:8];      // [RULE22]
			next_state.trk_lo = meas.track_period[7:0];       // [RULE23]
		end

		// 2.6 us timebase shared by period and delay counters downstream
		if (clk_en) begin
			if (state.tick_cnt == TICK_LAST) begin
				next_state.tick_cnt = 5'h00;
				next_state.tick     = 1'b1;
			end else begin
				next_state.tick_cnt = state.tick_cnt + 5'h01;
			end
		end

		// gain scaler saturates so gains above unity cannot wrap
		next_state.out_valid = clk_en & sample_valid;
		if (clk_en && sample_valid) begin
			if (shifted > 17'sh0007f)
				next_state.out_sample = 8'h7f;                // [RULE1]
			else if (shifted < -17'sh00080)
				next_state.out_sample = 8'h80;                // [RULE1]
			else
				next_state.out_sample = shifted[7:0];         // [RULE1]
		end

		// hold everything while the clock enable is low
		if (!clk_en)
			next_state = state;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register with synchronous reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= RESET_STATE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign reg_rdata    = state.rdata;
	assign mem_raddr    = ptr;
	assign mem_wr       = state.mem_wr;
	assign mem_waddr    = state.mem_waddr;
	assign mem_wdata    = state.mem_wdata;
	assign scaled_valid = state.out_valid;
	assign scaled_out   = state.out_sample;
	assign unit_tick    = state.tick;

	// decoded configuration
	always_comb begin
		cfg                 = '0;
		cfg.gain            = state.gain;
		cfg.boost_rail_code = state.boost[hpc_pkg::BOOST_CODE_LSB +: 5];            // [RULE2]
		cfg.boost_rail_mv   = hpc_pkg::BOOST_BASE_MV +
		                      14'(14'(cfg.boost_rail_code) * hpc_pkg::BOOST_STEP_MV); // [RULE2]
		cfg.input_guard_enable = state.guard_level[hpc_pkg::GUARD_ENABLE_BIT];      // [RULE3]
		cfg.input_guard_level  = state.guard_level[6:0];                            // [RULE3]
		cfg.input_guard_time   = state.guard_time;                                  // [RULE4]
		cfg.duration_source_select  = state.continuous_drive_ctrl[hpc_pkg::CONT_DURATION_BIT];  // [RULE9]
		cfg.closed_loop             = state.continuous_drive_ctrl[hpc_pkg::CONT_CLOSED_BIT];    // [RULE10]
		cfg.resonance_detect_enable = state.continuous_drive_ctrl[hpc_pkg::CONT_DETECT_BIT];    // [RULE11]
		cfg.auto_braking_enable     = state.continuous_drive_ctrl[hpc_pkg::CONT_BRAKE_BIT];
		case (state.continuous_drive_ctrl[hpc_pkg::CONT_PERIODS_LSB +: 2])
			2'h1:    cfg.bemf_periods = 3'h2;                                     // [RULE8]
			2'h2:    cfg.bemf_periods = 3'h4;                                     // [RULE8]
			default: cfg.bemf_periods = 3'h1;                                     // [RULE8]
		endcase
		cfg.preset_period      = {state.pre_hi, state.pre_lo};                      // [RULE13]
		cfg.drive_delay        = {state.dly_hi[3:0], state.dly_lo};                 // [RULE14]
		cfg.diagnostic_select  = state.diag_ctrl[hpc_pkg::DIAG_SELECT_BIT];         // [RULE15]
		cfg.protection_disable = state.diag_ctrl[hpc_pkg::DIAG_PROTECT_BIT];        // [RULE16]
		cfg.hw_adjust_mode     = state.adjust[hpc_pkg::ADJUST_MODE_BIT];            // [RULE20]
		cfg.diagnosis_start    = state.diag_ctrl[hpc_pkg::DIAG_START_BIT];          // [RULE17]
		cfg.supply_start       = state.diag_ctrl[hpc_pkg::DIAG_SUPPLY_GO_BIT];      // [RULE18]
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence data_write_s;
		wr_hit && reg_req.addr == hpc_pkg::OFS_DATA_PORT;
	endsequence

	sequence data_read_s;
		rd_hit && reg_req.addr == hpc_pkg::OFS_DATA_PORT;
	endsequence

	sequence diag_done_s;
		clk_en && meas.diag_done && state.diag_ctrl[hpc_pkg::DIAG_START_BIT] && !wr_hit;
	endsequence

	gain_scale_a: assert property (clk_en && sample_valid && sample_in == 8'sh10 // [RULE1]
		|=> scaled_valid && scaled_out == 8'(({8'h00, $past(state.gain)} << 4) >> 7)
		    || $past(state.gain) > 8'h80)
		else $error("gain scaling wrong");

	rail_code_a: assert property (wr_hit && reg_req.addr == hpc_pkg::OFS_BOOST_VOLTAGE // [RULE2]
		|=> cfg.boost_rail_mv == 14'd6000 + 14'd142 * 14'($past(reg_req.wdata[5:1])))
		else $error("boost rail millivolts wrong");

	reset_values_a: assert property ($rose(rst_n) |-> cfg.input_guard_level == 7'h3f // [RULE12]
		&& cfg.input_guard_enable && state.continuous_drive_ctrl == 8'h99 && state.offset == 8'h80
		&& cfg.preset_period == 16'h0725 && cfg.drive_delay == 12'h05d && state.guard_time == 8'h12)
		else $error("reset values wrong");

	mem_write_a: assert property (data_write_s |=> mem_wr && mem_waddr == $past(ptr) // [RULE6]
		&& mem_wdata == $past(reg_req.wdata) ##1 !mem_wr || $past(wr_hit))
		else $error("data port write not forwarded");

	ptr_write_a: assert property (data_write_s |=> ptr == $past(ptr) + 13'h0001) // [RULE7]
		else $error("pointer did not advance on write");

	ptr_read_a: assert property (data_read_s |=> ptr == $past(ptr) + 13'h0001 // [RULE7]
		&& reg_rdata == $past(mem_rdata))
		else $error("data port read wrong");

	bemf_count_a: assert property (state.continuous_drive_ctrl[6:5] == 2'h2 |-> cfg.bemf_periods == 3'h4 // [RULE8]
		or state.continuous_drive_ctrl[6:5] != 2'h2)
		else $error("four-period decode wrong");

	diag_result_a: assert property (diag_done_s ##0 state.diag_ctrl[6] // [RULE17]
		|=> state.load_res == $past(meas.diag_value) && !cfg.diagnosis_start)
		else $error("resistance result not stored");

	offset_result_a: assert property (diag_done_s ##0 !state.diag_ctrl[6] // [RULE19]
		|=> state.offset == $past(meas.diag_value) && !cfg.diagnosis_start)
		else $error("offset result not stored");

	supply_result_a: assert property (clk_en && meas.supply_done && cfg.supply_start && !wr_hit // [RULE18]
		|=> state.supply == $past(meas.supply_value) && !cfg.supply_start)
		else $error("supply result not stored");

	track_store_a: assert property (clk_en && meas.track_valid // [RULE23]
		|=> {state.trk_hi, state.trk_lo} == $past(meas.track_period))
		else $error("tracked period not stored");

	// a write pulse caught by the freeze holds rather than vanishing
	freeze_hold_a: assert property (!clk_en |=> $stable(state.gain) && $stable(ptr)
		&& $stable(mem_wr) && $stable(reg_rdata))
		else $error("state moved while enable low");

endmodule

`default_nettype wire

// ---- verif/hpc_mem_model.sv ----
// wave memory model on the far side of the data port
// assumes registered write pulse and addresses from the bank
`timescale 1ns/1ps
`default_nettype none
module hpc_mem_model (
	// clock
	input  wire logic        sys_clk,
	// read and write sides
	input  wire logic [12:0] raddr,
	output logic [7:0]       rdata,
	input  wire logic        wr,
	input  wire logic [12:0] waddr,
	input  wire logic [7:0]  wdata
);
	// unwritten bytes stay unknown, so a stray fetch never matches
	logic [7:0] mem [0:8191];
	assign rdata = mem[raddr];
	always @(posedge sys_clk) begin
		if (wr) mem[waddr] <= wdata;
	end
endmodule
`default_nettype wire

// ---- verif/tb_haptic_playback_config_regs.sv ----
// self-checking bench: reset values, access, memory port, results
// assumes the memory model beside the bank and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_haptic_playback_config_regs;
	logic                  sys_clk = 1'b0, rst_n = 1'b0, sample_valid = 1'b0, seen = 1'b0;
	logic signed [7:0]     sample_in = 8'sh00, scaled_out;
	logic                  mem_wr, scaled_valid, tick, clk_en = 1'b1;
	logic [7:0]            reg_rdata, mem_rdata, mem_wdata, d, md [3];
	logic [12:0]           mem_raddr, mem_waddr;
	hpc_pkg::hpc_reg_req_t req = '0;
	hpc_pkg::hpc_meas_t    meas = '0;
	hpc_pkg::hpc_cfg_t     cfg;
	logic [7:0]            exp_q [$];
	int                    error_cnt = 0, comparisons = 0;
	// offset and reset value pairs
	logic [15:0] rv [20] = '{16'h3980, 16'h3a62, 16'h3ebf, 16'h3f12, 16'h4000, 16'h4100,
		16'h4899, 16'h4907, 16'h4a25, 16'h4b00, 16'h4c5d, 16'h5f00, 16'h6000, 16'h6180,
		16'h6200, 16'h6600, 16'h6800, 16'h6900, 16'h6a00, 16'h6b00};
	always #50 sys_clk = ~sys_clk;
	hpc_config_regs u_hpc_config_regs (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_req(req), .reg_rdata(reg_rdata), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
		.mem_wr(mem_wr), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .meas(meas),
		.sample_valid(sample_valid), .sample_in(sample_in), .scaled_valid(scaled_valid),
		.scaled_out(scaled_out), .cfg(cfg), .unit_tick(tick));
	hpc_mem_model u_hpc_mem_model (.sys_clk(sys_clk), .raddr(mem_raddr), .rdata(mem_rdata),
		.wr(mem_wr), .waddr(mem_waddr), .wdata(mem_wdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// each access idles a cycle after, so strobes never toggle twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		req = '{1'b1, 1'b0, a, v};
		@(negedge sys_clk) req = '0;
		@(negedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge sys_clk) req = '0;
		@(negedge sys_clk);
	endtask
	task automatic blip;
		@(negedge sys_clk) meas = '0;
		@(negedge sys_clk);
	endtask
	// one sample at gain g; the scaled result stands one cycle after
	task automatic smp(input logic [7:0] g, input logic [7:0] s, input logic [8:0] e);
		wr(8'h39, g);
		sample_in = s;
		sample_valid = 1'b1;
		@(negedge sys_clk) sample_valid = 1'b0;
		chk("scaled", {7'h00, e}, {scaled_valid, scaled_out});
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// read data lands one cycle after the strobe; take the oldest note
	always @(posedge sys_clk) seen <= req.rd & rst_n;
	always @(negedge sys_clk) if (seen) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
	initial begin
		#(3000 * 100);
		error_cnt++;
		wrap_up;
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hd8db));
		repeat (16) @(negedge sys_clk);
		rst_n = 1'b1;
		foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
		chk("preset", 16'h0725, cfg.preset_period);
		chk("guard", 16'hbf12,
			{cfg.input_guard_enable, cfg.input_guard_level, cfg.input_guard_time});
		foreach (rv[i]) begin
			d = 8'($urandom);
			wr(rv[i][15:8], d);
			rd(rv[i][15:8], rv[i][15:8] inside {8'h60, 8'h61, 8'h62} ? rv[i][7:0] : d);
		end
		rd(8'h50, 8'h00);
		$display("test registers done");
		wr(8'h3a, 8'h3e);
		chk("boost_mv", 16'h28a2, cfg.boost_rail_mv);
		for (int k = 0; k < 4; k++) begin
			wr(8'h48, {1'b0, k[1:0], {3{k[0]}}, 1'b0, k[0]});
			chk("cont", {k == 1 ? 3'd2 : k == 2 ? 3'd4 : 3'd1, {4{k[0]}}}, {cfg.bemf_periods,
				cfg.duration_source_select, cfg.closed_loop, cfg.resonance_detect_enable,
				cfg.auto_braking_enable});
		end
		wr(8'h4b, 8'hf3);
		wr(8'h4c, 8'h5d);
		chk("delay", 16'h035d, cfg.drive_delay);
		smp(8'h40, 8'h40, 9'h120);
		smp(8'h40, 8'h10, 9'h108);
		smp(8'hff, 8'h7f, 9'h17f);
		smp(8'hff, 8'h80, 9'h180);
		// a write while the enable is low must not land
		clk_en = 1'b0;
		wr(8'h39, 8'h11);
		clk_en = 1'b1;
		rd(8'h39, 8'hff);
		while (!tick) @(negedge sys_clk);
		repeat (hpc_pkg::UNIT_CYCLES - 1) @(negedge sys_clk);
		chk("tick_gap", 16'h0000, {15'h0000, tick});
		@(negedge sys_clk) chk("tick", 16'h0001, {15'h0000, tick});
		$display("test config done");
		wr(8'h40, 8'hff);
		wr(8'h41, 8'hfe);
		foreach (md[i]) begin
			md[i] = 8'($urandom);
			wr(8'h42, md[i]);
		end
		rd(8'h40, 8'he0);
		rd(8'h41, 8'h01);
		wr(8'h41, 8'hfe);
		wr(8'h40, 8'h1f);
		foreach (md[i]) rd(8'h42, md[i]);
		$display("test memory done");
		wr(8'h5f, 8'h61);
		chk("diag_cfg", 16'h0003, {cfg.diagnostic_select, cfg.protection_disable});
		wr(8'h66, 8'h40);
		chk("adjust", 16'h0001, {15'h0000, cfg.hw_adjust_mode});
		meas.diag_done = 1'b1;
		meas.diag_value = 8'h5a;
		blip;
		rd(8'h60, 8'h5a);
		rd(8'h5f, 8'h60);
		wr(8'h5f, 8'h03);
		meas.diag_done = 1'b1;
		meas.diag_value = 8'h3c;
		meas.supply_done = 1'b1;
		meas.supply_value = 8'hc7;
		blip;
		rd(8'h61, 8'h3c);
		rd(8'h62, 8'hc7);
		rd(8'h5f, 8'h00);
		meas.diag_done = 1'b1;
		meas.diag_value = 8'h11;
		meas.f0_done = 1'b1;
		meas.f0_period = 16'h1234;
		meas.track_valid = 1'b1;
		meas.track_period = 16'hedcb;
		blip;
		rd(8'h61, 8'h3c);
		rd(8'h68, 8'h12);
		rd(8'h69, 8'h34);
		rd(8'h6a, 8'hed);
		rd(8'h6b, 8'hcb);
		$display("test results done");
		wrap_up;
	end
endmodule
`default_nettype wire
